// File: shared/pin_cfg_pkg.sv
package pin_cfg_pkg;

  // -----------------------------------------------------------------------
  // register indices on the serial control side
  // -----------------------------------------------------------------------
  localparam int unsigned REG_CNT         = 8;
  localparam logic [2:0] IDX_HS_MODE      = 3'h0;
  localparam logic [2:0] IDX_AUX_MODE     = 3'h1;
  localparam logic [2:0] IDX_RX_SET       = 3'h2;
  localparam logic [2:0] IDX_TERM_PLS_AB  = 3'h3;
  localparam logic [2:0] IDX_TERM_PLS_CD  = 3'h4;
  localparam logic [2:0] IDX_EQ_AB        = 3'h5;
  localparam logic [2:0] IDX_EQ_CD        = 3'h6;
  localparam logic [2:0] IDX_TX_SET       = 3'h7;

  // -----------------------------------------------------------------------
  // field positions
  // -----------------------------------------------------------------------
  localparam int unsigned POS_ENABLE      = 6;
  localparam int unsigned POS_MODE_HI     = 5;
  localparam int unsigned POS_MODE_LO     = 4;
  localparam int unsigned POS_SRC_HI      = 1;
  localparam int unsigned POS_SRC_LO      = 0;
  localparam int unsigned POS_IN_TERM     = 0;
  localparam int unsigned POS_PE_HI       = 3;
  localparam int unsigned POS_PE_LO       = 2;
  localparam int unsigned POS_OUT_TERM    = 1;
  localparam int unsigned POS_OUT_CUR     = 0;

  // -----------------------------------------------------------------------
  // fixed values and reset values
  // -----------------------------------------------------------------------
  localparam logic [1:0] MODE_QUAD        = 2'h0;
  localparam logic       AUX_ALWAYS_ON    = 1'h1;
  localparam logic       IN_TERM_ALWAYS   = 1'h1;
  localparam logic [7:0] TERM_PULSE_OFF   = 8'h00;
  localparam logic [7:0] REG_RESET        = 8'h00;
  localparam logic [7:0] RDATA_IDLE       = 8'h00;

  // -----------------------------------------------------------------------
  // control state
  // -----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_PIN    = 2'b01,
    ST_SERIAL = 2'b10
  } cfg_state_e;

endpackage

// File: hdl/source_route_decode.sv
`timescale 1ns/1ps
module source_route_decode (
  input  wire logic       enable_i,
  input  wire logic [1:0] select_i,
  output logic      [3:0] route_o
);

  // -----------------------------------------------------------------------
  // one-hot source route, a/b/c/d for codes 0..3
  // -----------------------------------------------------------------------
  // gated by enable so a disabled switch connects no source at all
  always_comb begin
    route_o = 4'h0;
    if (enable_i) begin
      route_o[select_i] = 1'b1;
    end
  end

endmodule

// File: hdl/parallel_pin_config_decoder.sv
`timescale 1ns/1ps
// Contract
// - enable pin low: lanes off, standby; high: lanes on.
// - pin mode forces high-speed switching to quad bundling.
// - two select pins route source a/b/c/d lanes to outputs.
// - pin mode keeps auxiliary switch enabled, quad, whatever the enable.
// - same select pins route a/b/c/d auxiliary lines to common port.
// - pin mode holds every input termination connected.
// - pin mode zeroes both termination-pulse registers.
// - one equalizer pin sets all sixteen inputs: low 6 dB, high 12 dB.
// - equalizer pin copied into every bit of both equalizer registers.
// - two pins set pre-emphasis: 0, 2, 4, 6 dB.
// - output termination pin high connects, low disconnects.
// - current pin low gives 10 mA, high 20 mA.
// - pins govern after reset until first serial access only.
module parallel_pin_config_decoder #(
  parameter int unsigned LANES = 4
) (
  input  wire logic                sys_clk_i,
  input  wire logic                rst_i,
  // configuration pins
  input  wire logic                pin_lane_enable_i,
  input  wire logic [1:0]          pin_source_select_i,
  input  wire logic                pin_equalizer_level_i,
  input  wire logic [1:0]          pin_preemphasis_level_i,
  input  wire logic                pin_output_termination_i,
  input  wire logic                pin_output_current_i,
  // serial control side
  input  wire logic                serial_access_i,
  input  wire logic                serial_write_i,
  input  wire logic [2:0]          serial_index_i,
  input  wire logic [7:0]          serial_wdata_i,
  output logic      [7:0]          serial_rdata_o,
  // configuration state
  output logic                     pin_mode_o,
  output logic                     lanes_on_o,
  output logic                     standby_o,
  output logic                     hs_quad_mode_o,
  output logic      [LANES-1:0]    hs_route_o,
  output logic                     aux_enable_o,
  output logic                     aux_quad_mode_o,
  output logic      [LANES-1:0]    aux_route_o,
  output logic                     in_term_on_o,
  output logic      [15:0]         term_pulse_o,
  output logic      [15:0]         eq_high_o,
  output logic      [1:0]          preemphasis_o,
  output logic                     out_term_on_o,
  output logic                     out_current_high_o
);
  import pin_cfg_pkg::*;

  // -----------------------------------------------------------------------
  // state
  // -----------------------------------------------------------------------
  typedef struct packed {
    cfg_state_e                    state;
    logic [REG_CNT-1:0][7:0]       regs;
    logic [7:0]                    rdata;
  } cfg_s;

  cfg_s cur_q;
  cfg_s nxt_d;

  // image of the registers built from the pins this cycle
  logic [REG_CNT-1:0][7:0] pin_image;

  // -----------------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------------
  // mode byte: enable in bit 6, quad code, source in the low two bits
  function automatic logic [7:0] mode_byte(input logic       en,
                                           input logic [1:0] src);
    logic [7:0] b;
    b = 8'h00;
    b[POS_ENABLE] = en;
    b[POS_MODE_HI:POS_MODE_LO] = MODE_QUAD;
    b[POS_SRC_HI:POS_SRC_LO] = src;
    return b;
  endfunction

  // a byte with every bit equal to one level
  function automatic logic [7:0] fill_byte(input logic v);
    return {8{v}};
  endfunction

  // -----------------------------------------------------------------------
  // pin image
  // -----------------------------------------------------------------------
  // pins are static board straps, so no synchroniser is placed on them
  always_comb begin
    pin_image = '0;
    // lane enable from its pin, mode forced to quad
    pin_image[IDX_HS_MODE] =
      mode_byte(pin_lane_enable_i, pin_source_select_i);
    // auxiliary switch always on, quad, same select pins
    pin_image[IDX_AUX_MODE] =
      mode_byte(AUX_ALWAYS_ON, pin_source_select_i);
    // input termination held connected
    pin_image[IDX_RX_SET][POS_IN_TERM] = IN_TERM_ALWAYS;
    // no termination pulse on a source change
    pin_image[IDX_TERM_PLS_AB] = TERM_PULSE_OFF;
    pin_image[IDX_TERM_PLS_CD] = TERM_PULSE_OFF;
    // one equalizer level everywhere
    pin_image[IDX_EQ_AB] = fill_byte(pin_equalizer_level_i);
    pin_image[IDX_EQ_CD] = fill_byte(pin_equalizer_level_i);
    // transmitter settings
    pin_image[IDX_TX_SET][POS_PE_HI:POS_PE_LO] =
      pin_preemphasis_level_i;
    pin_image[IDX_TX_SET][POS_OUT_TERM] = pin_output_termination_i;
    pin_image[IDX_TX_SET][POS_OUT_CUR] = pin_output_current_i;
  end

  // -----------------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------------
  // pin mode tracks the pins every cycle; the first serial access hands
  // control over for good, only a reset brings pin mode back
  always_comb begin
    nxt_d = cur_q;
    case (cur_q.state)
      ST_PIN: begin
        nxt_d.regs = pin_image;
        if (serial_access_i) begin
          nxt_d.state = ST_SERIAL;
        end
      end
      ST_SERIAL: begin
        nxt_d.state = ST_SERIAL;
      end
      default: begin
        nxt_d.state = ST_PIN;
      end
    endcase
    // a write on the first access already lands, so it overrides the
    // pin image copied in the same cycle
    if (serial_access_i && serial_write_i) begin
      nxt_d.regs[serial_index_i] = serial_wdata_i;
    end
    // read data is registered, valid the cycle after the access
    if (serial_access_i && !serial_write_i) begin
      nxt_d.rdata = cur_q.regs[serial_index_i];
    end else begin
      nxt_d.rdata = RDATA_IDLE;
    end
  end

  // -----------------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------------
  // reset returns to pin mode; the pin image loads on the first edge after
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cur_q.state <= ST_PIN;
      cur_q.regs  <= {REG_CNT{REG_RESET}};
      cur_q.rdata <= RDATA_IDLE;
    end else begin
      cur_q <= nxt_d;
    end
  end

  // -----------------------------------------------------------------------
  // route decoders
  // -----------------------------------------------------------------------
  // high-speed lanes: output lane n follows lane n of the chosen source
  source_route_decode u_hs_route (
    .enable_i (cur_q.regs[IDX_HS_MODE][POS_ENABLE]),
    .select_i (cur_q.regs[IDX_HS_MODE][POS_SRC_HI:POS_SRC_LO]),
    .route_o  (hs_route_o)
  );

  // auxiliary lines have their own select and enable bits in the aux mode register
  source_route_decode u_aux_route (
    .enable_i (cur_q.regs[IDX_AUX_MODE][POS_ENABLE]),
    .select_i (cur_q.regs[IDX_AUX_MODE][POS_SRC_HI:POS_SRC_LO]),
    .route_o  (aux_route_o)
  );

  // -----------------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------------
  // every field is decoded from the register bytes, except pin_mode_o from the state and read data
  always_comb begin
    serial_rdata_o     = cur_q.rdata;
    pin_mode_o         = (cur_q.state == ST_PIN);
    lanes_on_o         = cur_q.regs[IDX_HS_MODE][POS_ENABLE];
    standby_o          = !cur_q.regs[IDX_HS_MODE][POS_ENABLE];
    hs_quad_mode_o     =
      (cur_q.regs[IDX_HS_MODE][POS_MODE_HI:POS_MODE_LO] == MODE_QUAD);
    aux_enable_o       = cur_q.regs[IDX_AUX_MODE][POS_ENABLE];
    aux_quad_mode_o    =
      (cur_q.regs[IDX_AUX_MODE][POS_MODE_HI:POS_MODE_LO] == MODE_QUAD);
    in_term_on_o       = cur_q.regs[IDX_RX_SET][POS_IN_TERM];
    term_pulse_o       = {cur_q.regs[IDX_TERM_PLS_CD],
                          cur_q.regs[IDX_TERM_PLS_AB]};
    eq_high_o          = {cur_q.regs[IDX_EQ_CD],
                          cur_q.regs[IDX_EQ_AB]};
    preemphasis_o      = cur_q.regs[IDX_TX_SET][POS_PE_HI:POS_PE_LO];
    out_term_on_o      = cur_q.regs[IDX_TX_SET][POS_OUT_TERM];
    out_current_high_o = cur_q.regs[IDX_TX_SET][POS_OUT_CUR];
  end

endmodule

// File: tb/pin_cfg_chk.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// pin mode decode checks
// ---------------------------------------------------------------
module pin_cfg_chk #(parameter int unsigned LANES = 4) (
  input wire logic             sys_clk_i,
  input wire logic             rst_i,
  input wire logic             pin_lane_enable_i,
  input wire logic [1:0]       pin_source_select_i,
  input wire logic             pin_equalizer_level_i,
  input wire logic [1:0]       pin_preemphasis_level_i,
  input wire logic             pin_output_termination_i,
  input wire logic             pin_output_current_i,
  input wire logic             serial_access_i,
  input wire logic             pin_mode_o,
  input wire logic             lanes_on_o,
  input wire logic             standby_o,
  input wire logic             hs_quad_mode_o,
  input wire logic [LANES-1:0] hs_route_o,
  input wire logic             aux_enable_o,
  input wire logic             aux_quad_mode_o,
  input wire logic [LANES-1:0] aux_route_o,
  input wire logic             in_term_on_o,
  input wire logic [15:0]      term_pulse_o,
  input wire logic [15:0]      eq_high_o,
  input wire logic [1:0]       preemphasis_o,
  input wire logic             out_term_on_o,
  input wire logic             out_current_high_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // an access in the same cycle wins, so only quiet pin cycles count
  logic live;
  assign live = pin_mode_o && !serial_access_i;
  lane_enable_a: assert property (live |=>
    lanes_on_o == $past(pin_lane_enable_i) && standby_o == !lanes_on_o)
    else $error("lane enable wrong");
  hs_quad_a: assert property (live |=> hs_quad_mode_o)
    else $error("hs mode not quad");
  hs_route_a: assert property (live |=> hs_route_o ==
    ($past(pin_lane_enable_i) ? LANES'(1) << $past(pin_source_select_i) : '0))
    else $error("hs route wrong");
  aux_route_a: assert property (live |=> aux_enable_o &&
    aux_quad_mode_o && (aux_route_o == LANES'(1) << $past(pin_source_select_i)))
    else $error("aux route wrong");
  in_term_a: assert property (live |=> in_term_on_o && !(|term_pulse_o))
    else $error("input termination wrong");
  eq_copy_a: assert property (live |=>
    eq_high_o == {16{$past(pin_equalizer_level_i)}}) else $error("eq wrong");
  tx_set_a: assert property (live |=>
    preemphasis_o == $past(pin_preemphasis_level_i) &&
    out_term_on_o == $past(pin_output_termination_i) &&
    out_current_high_o == $past(pin_output_current_i))
    else $error("tx settings wrong");
  serial_end_a: assert property (serial_access_i |=> !pin_mode_o)
    else $error("pin mode kept after access");
  pins_ignored_a: assert property (!pin_mode_o && !serial_access_i |=>
    !pin_mode_o && $stable({preemphasis_o, out_term_on_o, eq_high_o}))
    else $error("pins still govern");
  cover property (serial_access_i && pin_mode_o);
  cover property (live && pin_lane_enable_i && pin_source_select_i == 2'h3);
  cover property (!pin_mode_o && serial_access_i);
endmodule

bind parallel_pin_config_decoder pin_cfg_chk #(.LANES(LANES)) i_pin_cfg_chk (
  .sys_clk_i, .rst_i, .pin_lane_enable_i, .pin_source_select_i,
  .pin_equalizer_level_i, .pin_preemphasis_level_i, .pin_output_termination_i,
  .pin_output_current_i, .serial_access_i, .pin_mode_o, .lanes_on_o,
  .standby_o, .hs_quad_mode_o, .hs_route_o, .aux_enable_o, .aux_quad_mode_o,
  .aux_route_o, .in_term_on_o, .term_pulse_o, .eq_high_o, .preemphasis_o,
  .out_term_on_o, .out_current_high_o);

// File: tb/pin_strap_model.sv
`timescale 1ns/1ps
// board straps; image is {enable, source[1:0], eq, pe[1:0], oterm, cur}
module pin_strap_model (
  input  wire logic [7:0] strap_i,
  output logic            lane_enable_o,
  output logic [1:0]      source_select_o,
  output logic            equalizer_level_o,
  output logic [1:0]      preemphasis_o,
  output logic            output_termination_o,
  output logic            output_current_o
);
  // each pin is tied hard to one or zero, never left floating
  assign {lane_enable_o, source_select_o, equalizer_level_o, preemphasis_o,
          output_termination_o, output_current_o} = strap_i;
endmodule

// File: tb/parallel_pin_config_decoder_tb.sv
`timescale 1ns/1ps
module parallel_pin_config_decoder_tb;
  import pin_cfg_pkg::*;
  logic        sys_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  strap = 8'h00;
  logic        serial_access_i = 1'b0;
  logic        serial_write_i = 1'b0;
  logic [2:0]  serial_index_i = 3'h0;
  logic [7:0]  serial_wdata_i = 8'h00;
  logic [7:0]  serial_rdata_o;
  logic        pin_lane_enable_i, pin_equalizer_level_i, pin_output_current_i;
  logic        pin_output_termination_i, pin_mode_o, lanes_on_o, standby_o;
  logic        hs_quad_mode_o, aux_enable_o, aux_quad_mode_o, in_term_on_o;
  logic        out_term_on_o, out_current_high_o;
  logic [1:0]  pin_source_select_i, pin_preemphasis_level_i, preemphasis_o;
  logic [3:0]  hs_route_o, aux_route_o;
  logic [15:0] term_pulse_o, eq_high_o;
  logic [31:0] outs;
  int          err_count = 0;
  int          samples_checked = 0;

  // ---------------------------------------------------------------
  // clock, design and straps
  // ---------------------------------------------------------------
  always #12.5 sys_clk_i = ~sys_clk_i;
  parallel_pin_config_decoder i_parallel_pin_config_decoder (.sys_clk_i,
    .rst_i, .pin_lane_enable_i, .pin_source_select_i, .pin_equalizer_level_i,
    .pin_preemphasis_level_i, .pin_output_termination_i, .pin_output_current_i,
    .serial_access_i, .serial_write_i, .serial_index_i, .serial_wdata_i,
    .serial_rdata_o, .pin_mode_o, .lanes_on_o, .standby_o, .hs_quad_mode_o,
    .hs_route_o, .aux_enable_o, .aux_quad_mode_o, .aux_route_o, .in_term_on_o,
    .term_pulse_o, .eq_high_o, .preemphasis_o, .out_term_on_o,
    .out_current_high_o);
  pin_strap_model i_pin_strap_model (.strap_i(strap),
    .lane_enable_o(pin_lane_enable_i), .source_select_o(pin_source_select_i),
    .equalizer_level_o(pin_equalizer_level_i),
    .preemphasis_o(pin_preemphasis_level_i),
    .output_termination_o(pin_output_termination_i),
    .output_current_o(pin_output_current_i));
  // one word of flags and routes keeps the compare count low
  assign outs = {13'h0, lanes_on_o, standby_o, hs_quad_mode_o, aux_enable_o,
    aux_quad_mode_o, in_term_on_o, pin_mode_o, preemphasis_o, out_term_on_o,
    out_current_high_o, hs_route_o, aux_route_o};

  function automatic logic [31:0] img(input logic [7:0] s);
    return {13'h0, s[7], !s[7], 5'h1f, s[3:0],
            s[7] ? 4'h1 << s[6:5] : 4'h0, 4'h1 << s[6:5]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // pins move at the falling edge and are looked at one cycle later
  task automatic strap_step(input logic [7:0] s);
    @(negedge sys_clk_i) strap = s;
    @(negedge sys_clk_i);
  endtask
  // one-cycle access pulse; read data is settled at the next falling edge
  task automatic ser(input logic wr, input logic [2:0] idx,
                     input logic [7:0] d);
    @(negedge sys_clk_i);
    serial_access_i = 1'b1;
    serial_write_i = wr;
    serial_index_i = idx;
    serial_wdata_i = d;
    @(negedge sys_clk_i) serial_access_i = 1'b0;
  endtask
  task automatic complete_run();
    if (err_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    repeat (6) @(negedge sys_clk_i);
    rst_i = 1'b0;
    for (int i = 0; i < 256; i++) begin
      strap_step(8'(i));
      chk(outs, img(8'(i)));
      chk({eq_high_o, term_pulse_o}, {{16{i[4]}}, 16'h0});
    end
    strap_step(8'hb6);
    ser(1'b0, IDX_HS_MODE, 8'h00);
    chk(serial_rdata_o, 8'h41);
    strap_step(8'h49);
    chk(outs, img(8'hb6) ^ 32'h1000);
    ser(1'b0, IDX_EQ_CD, 8'h00);
    chk(serial_rdata_o, 8'hff);
    // read data stands for one cycle only, then drops back to idle
    @(negedge sys_clk_i);
    chk(serial_rdata_o, 8'h00);
    ser(1'b0, IDX_TERM_PLS_AB, 8'h00);
    chk(serial_rdata_o, 8'h00);
    ser(1'b1, IDX_TX_SET, 8'h0d);
    chk({preemphasis_o, out_term_on_o, out_current_high_o}, 4'hd);
    // serial writes reach modes the pins never select: non-quad, aux off
    ser(1'b1, IDX_HS_MODE, 8'h63);
    ser(1'b1, IDX_AUX_MODE, 8'h12);
    chk(outs, 32'h00042d80);
    // a second reset hands control back to the straps
    @(negedge sys_clk_i) rst_i = 1'b1;
    repeat (6) @(negedge sys_clk_i);
    rst_i = 1'b0;
    strap_step(8'h49);
    chk(outs, img(8'h49));
    // a write as first access wins over the pin image of that cycle
    ser(1'b1, IDX_EQ_AB, 8'h5a);
    strap_step(8'hff);
    chk({pin_mode_o, eq_high_o}, {1'b0, 16'h005a});
    complete_run();
  end
  // whole run is near 550 cycles, so 2000 leaves room
  initial begin
    #(25 * 2000);
    err_count++;
    complete_run();
  end
endmodule
